// ===== verilog/oct_switch_pkg.sv
// constants and carrier types for the octal switch channel control
package oct_switch_pkg;
  localparam int NUM_CH      = 8;
  localparam int FRAME_BITS  = 16;
  localparam int CMD_HI      = 15;
  localparam int CMD_LO      = 14;
  localparam int ADDR_HI     = 10;
  localparam int ADDR_LO     = 8;
  localparam int DATA_HI     = 7;
  localparam int BIT_MOD_W   = 3;
  localparam int FILT_CYC    = 100;
  localparam int OVLD_CYC    = 200;
  localparam int CNT_W       = 16;
  localparam logic [1:0] CMD_DIAG  = 2'h0;
  localparam logic [1:0] CMD_READ  = 2'h1;
  localparam logic [1:0] CMD_RESET = 2'h2;
  localparam logic [1:0] CMD_WRITE = 2'h3;
  localparam logic [2:0] ADR_MAP = 3'h1;
  localparam logic [2:0] ADR_BOL = 3'h2;
  localparam logic [2:0] ADR_OVL = 3'h3;
  localparam logic [2:0] ADR_OVT = 3'h4;
  localparam logic [2:0] ADR_SLE = 3'h5;
  localparam logic [2:0] ADR_STA = 3'h6;
  localparam logic [2:0] ADR_CTL = 3'h7;
  localparam logic [7:0] MAP_RST = 8'h08;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [1:0] DG_NORMAL = 2'h3;
  localparam logic [1:0] DG_OVER   = 2'h2;
  localparam logic [1:0] DG_OPEN   = 2'h1;
  localparam logic [1:0] DG_SHORT  = 2'h0;
  localparam logic [15:0] READ_HDR = 16'h4000;

  typedef struct packed {
    logic [7:0] input_map;
    logic [7:0] combine_logic_select;
    logic [7:0] overload_policy_select;
    logic [7:0] overtemp_policy_select;
    logic [7:0] slew_speed_select;
    logic [7:0] serial_on_off_bits;
  } cfg_t;

  typedef struct packed {
    logic [7:0] overtemp;
    logic [7:0] current_limit;
    logic [7:0] open_load;
    logic [7:0] short_gnd;
  } sense_t;
endpackage

// ===== verilog/octal_switch_channel_control.sv
// octal low-side switch control, protection and serial link logic
//
// Behaviour
// (R1) per-channel AND/OR combine select, eight channels
// (R2) OR: either input; AND: both inputs
// (R3) serial command bit one means on
// (R4) polarity pin high: active high inputs
// (R5) direct inputs a-c feed channels one-three
// (R6) mappable input drives mapped channels, default four
// (R7) per-channel fast/slow slew select bit
// (R8) overtemperature turns channel off, records fault
// (R9) auto-restart when cooled and request on
// (R10) latching mode cleared by request rising edge
// (R11) overtemperature ignored while channel off
// (R12) reset low: sleep, outputs off, clear state
// (R13) after reset only parallel-driven channels on
// (R14) reset low clears shift register, outputs off
// (R15) limit-only: fault after filter time, stays on
// (R16) limit-shutdown: latch off after delay, edge clears
// (R17) fault output low on any channel error
// (R18) serial exchange only while select low
// (R19) select high: ignore clock/input, output hi-z
// (R20) four-wire link, sixteen-bit shift register
// (R21) decode diag, read, reset, write commands
// (R22) sample falling, shift out rising, msb first
// (R23) non-multiple-of-eight frame rejected, faults kept
// (R24) two diagnosis bits per channel encoding
// (R25) filter and switch-off delays are parameters
`timescale 1ns/10ps
module octal_switch_channel_control #(
  parameter int FILT_CYCLES = oct_switch_pkg::FILT_CYC,
  parameter int OVLD_CYCLES = oct_switch_pkg::OVLD_CYC
) (
  input  wire logic                   i_sys_clk,
  input  wire logic                   i_rst,
  input  wire logic                   i_reset_n,
  input  wire logic                   i_input_polarity_select,
  input  wire logic                   i_direct_parallel_input_a,
  input  wire logic                   i_direct_parallel_input_b,
  input  wire logic                   i_direct_parallel_input_c,
  input  wire logic                   i_mappable_parallel_input,
  input  wire logic                   i_spi_cs_n,
  input  wire logic                   i_spi_sclk,
  input  wire logic                   i_spi_si,
  input  wire oct_switch_pkg::sense_t i_sense,
  output logic [7:0]                  o_channel_drain_output,
  output logic [7:0]                  o_slew_speed_select,
  output logic                        o_spi_so,
  output logic                        o_spi_so_oe_n,
  output logic                        o_fault_o,
  output logic                        o_fault_oe_n
);
  import oct_switch_pkg::*;

  typedef struct packed {
    logic [1:0]  cs_s;
    logic [1:0]  sck_s;
    logic [1:0]  si_s;
    logic [1:0]  rn_s;
    logic [1:0]  pol_s;
    logic [3:0]  pin_s0;
    logic [3:0]  pin_s1;
    logic [31:0] sense_s0;
    logic [31:0] sense_s1;
    logic        cs_q;
    logic        sck_q;
    logic [15:0] shreg;
    logic [15:0] tx;
    logic [BIT_MOD_W-1:0] bit_mod;
    logic        any_clk;
    logic        rd_pend;
    logic [2:0]  rd_addr;
    cfg_t        cfg;
    logic [7:0]  req_q;
    logic [7:0]  on_q;
    logic [7:0]  ot_latch;
    logic [7:0]  ol_latch;
    logic [7:0]  ot_hold;
    logic [15:0] diag;
    logic [7:0]  err;
    logic [NUM_CH*CNT_W-1:0] lim_cnt;
    logic        so;
    logic        so_oe_n;
    logic        fault_oe_n;
  } state_t;

  state_t s_q;
  state_t s_d;

  function automatic logic [1:0] diag_code(input logic ot, input logic cl,
                                           input logic ol, input logic sg);
    if (ot || cl) diag_code = DG_OVER; // R24
    else if (ol) diag_code = DG_OPEN;
    else if (sg) diag_code = DG_SHORT;
    else diag_code = DG_NORMAL;
  endfunction

  function automatic logic [7:0] reg_read(input cfg_t c, input logic [2:0] a,
                                          input logic [7:0] sta);
    unique case (a)
      ADR_MAP: reg_read = c.input_map;
      ADR_BOL: reg_read = c.combine_logic_select;
      ADR_OVL: reg_read = c.overload_policy_select;
      ADR_OVT: reg_read = c.overtemp_policy_select;
      ADR_SLE: reg_read = c.slew_speed_select;
      ADR_STA: reg_read = sta;
      ADR_CTL: reg_read = c.serial_on_off_bits;
      default: reg_read = 8'h00;
    endcase
  endfunction

  function automatic logic lim_hit(input logic [15:0] c, input int lim);
    lim_hit = (c >= CNT_W'(lim)); // R25
  endfunction

  function automatic cfg_t cfg_default();
    cfg_default = '{MAP_RST, CFG_RST, CFG_RST, CFG_RST, CFG_RST, CFG_RST};
  endfunction

  always_comb begin
    logic        sleep;
    logic        fall;
    logic        rise;
    logic        cs_fall;
    logic        cs_rise;
    logic [3:0]  pin;
    logic [7:0]  par;
    logic [7:0]  req;
    logic [7:0]  req_rise;
    logic [7:0]  ot;
    logic [7:0]  cl;
    logic [15:0] cnt;
    logic        valid;
    logic [1:0]  cmd;
    logic [2:0]  adr;
    cnt   = 16'h0000;
    valid = 1'b0;
    cmd   = 2'h0;
    adr   = 3'h0;

    s_d = s_q;
    s_d.cs_s  = {s_q.cs_s[0], i_spi_cs_n};
    s_d.sck_s = {s_q.sck_s[0], i_spi_sclk};
    s_d.si_s  = {s_q.si_s[0], i_spi_si};
    s_d.rn_s  = {s_q.rn_s[0], i_reset_n};
    s_d.pol_s = {s_q.pol_s[0], i_input_polarity_select};
    s_d.pin_s0 = {i_mappable_parallel_input, i_direct_parallel_input_c,
                  i_direct_parallel_input_b, i_direct_parallel_input_a};
    s_d.pin_s1 = s_q.pin_s0;
    s_d.sense_s0 = i_sense;
    s_d.sense_s1 = s_q.sense_s0;
    s_d.cs_q  = s_q.cs_s[1];
    s_d.sck_q = s_q.sck_s[1];

    sleep   = !s_q.rn_s[1];
    cs_fall = s_q.cs_q && !s_q.cs_s[1];
    cs_rise = !s_q.cs_q && s_q.cs_s[1];
    fall    = !s_q.cs_s[1] && s_q.sck_q && !s_q.sck_s[1]; // R18 R19 R22
    rise    = !s_q.cs_s[1] && !s_q.sck_q && s_q.sck_s[1]; // R22

    pin = s_q.pol_s[1] ? s_q.pin_s1 : ~s_q.pin_s1; // R4
    par = {8{pin[3]}} & s_q.cfg.input_map; // R6
    par[2:0] = par[2:0] | pin[2:0]; // R5
    for (int i = 0; i < NUM_CH; i++) begin
      req[i] = s_q.cfg.combine_logic_select[i] ?
               (par[i] & s_q.cfg.serial_on_off_bits[i]) :
               (par[i] | s_q.cfg.serial_on_off_bits[i]); // R1 R2 R3
    end
    req_rise = req & ~s_q.req_q;
    s_d.req_q = req;

    ot = s_q.sense_s1[31:24] & s_q.on_q; // R11
    cl = s_q.sense_s1[23:16] & s_q.on_q;
    for (int i = 0; i < NUM_CH; i++) begin
      cnt = s_q.lim_cnt[i*CNT_W +: CNT_W];
      if (!cl[i]) cnt = 16'h0000;
      else if (cnt != 16'hFFFF) cnt = cnt + 16'h0001;
      s_d.lim_cnt[i*CNT_W +: CNT_W] = cnt;
      if (req_rise[i]) begin
        s_d.ot_latch[i] = 1'b0; // R10
        s_d.ol_latch[i] = 1'b0; // R16
      end
      if (!s_q.sense_s1[24+i]) s_d.ot_hold[i] = 1'b0; // R9
      if (ot[i]) s_d.ot_hold[i] = 1'b1; // R8
      if (ot[i] && s_q.cfg.overtemp_policy_select[i]) s_d.ot_latch[i] = 1'b1; // R10
      if (ot[i]) begin
        s_d.diag[2*i +: 2] = DG_OVER; // R8
        s_d.err[i] = 1'b1;
      end
      if (lim_hit(cnt, FILT_CYCLES) && !s_q.cfg.overload_policy_select[i]) begin
        s_d.diag[2*i +: 2] = DG_OVER; // R15
        s_d.err[i] = 1'b1;
      end
      if (lim_hit(cnt, OVLD_CYCLES) && s_q.cfg.overload_policy_select[i]) begin
        s_d.ol_latch[i] = 1'b1; // R16
        s_d.diag[2*i +: 2] = DG_OVER;
        s_d.err[i] = 1'b1;
      end
      if (!s_q.on_q[i] && (s_q.sense_s1[8+i] || s_q.sense_s1[i])) begin
        s_d.diag[2*i +: 2] = diag_code(1'b0, 1'b0, s_q.sense_s1[8+i],
                                       s_q.sense_s1[i]); // R24
        s_d.err[i] = 1'b1;
      end
    end

    // requested channel on unless latched off or still hot after a trip
    s_d.on_q = req & ~s_d.ot_latch & ~s_d.ol_latch &
               ~s_d.ot_hold; // R8 R9 R16

    // spi shift engine
    if (cs_fall) begin
      s_d.bit_mod = '0;
      s_d.any_clk = 1'b0;
      s_d.tx = s_q.rd_pend ? (READ_HDR | {5'h00, s_q.rd_addr,
               reg_read(s_q.cfg, s_q.rd_addr, s_q.on_q)}) : s_q.diag;
      s_d.rd_pend = 1'b0;
      s_d.so = s_d.tx[FRAME_BITS-1];
      s_d.so_oe_n = 1'b0;
    end
    if (rise && s_q.any_clk) begin
      s_d.tx = {s_q.tx[FRAME_BITS-2:0], 1'b0}; // R22
      s_d.so = s_q.tx[FRAME_BITS-2];
    end
    if (fall) begin
      s_d.shreg = {s_q.shreg[FRAME_BITS-2:0], s_q.si_s[1]}; // R20 R22
      s_d.bit_mod = s_q.bit_mod + 3'h1;
      s_d.any_clk = 1'b1;
    end
    if (cs_rise) begin
      s_d.so_oe_n = 1'b1; // R19
      s_d.so = 1'b0;
      cmd = s_q.shreg[CMD_HI:CMD_LO];
      adr = s_q.shreg[ADDR_HI:ADDR_LO];
      valid = s_q.any_clk && (s_q.bit_mod == '0); // R23
      if (valid) begin
        s_d.diag = {8{DG_NORMAL}};
        s_d.lim_cnt = '0;
        s_d.err = 8'h00;
        unique case (cmd) // R21
          CMD_DIAG: ;
          CMD_READ: begin
            s_d.rd_pend = 1'b1;
            s_d.rd_addr = adr;
          end
          CMD_RESET: begin
            s_d.cfg = cfg_default();
            s_d.ot_latch = 8'h00;
            s_d.ol_latch = 8'h00;
          end
          CMD_WRITE: begin
            unique case (adr)
              ADR_MAP: s_d.cfg.input_map = s_q.shreg[DATA_HI:0];
              ADR_BOL: s_d.cfg.combine_logic_select = s_q.shreg[DATA_HI:0];
              ADR_OVL: s_d.cfg.overload_policy_select = s_q.shreg[DATA_HI:0];
              ADR_OVT: s_d.cfg.overtemp_policy_select = s_q.shreg[DATA_HI:0];
              ADR_SLE: s_d.cfg.slew_speed_select = s_q.shreg[DATA_HI:0]; // R7
              ADR_CTL: s_d.cfg.serial_on_off_bits = s_q.shreg[DATA_HI:0];
              default: ;
            endcase
          end
        endcase
      end
    end

    s_d.fault_oe_n = ~(|s_d.err); // R17
    if (sleep) begin
      s_d.shreg = 16'h0000; // R14
      s_d.tx = 16'h0000;
      s_d.cfg.serial_on_off_bits = CFG_RST; // R12
      s_d.diag = {8{DG_NORMAL}};
      s_d.err = 8'h00;
      s_d.on_q = 8'h00; // R12 R13
      s_d.ot_latch = 8'h00;
      s_d.ol_latch = 8'h00;
      s_d.lim_cnt = '0;
      s_d.ot_hold = 8'h00;
      s_d.rd_pend = 1'b0;
      s_d.fault_oe_n = 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      s_q <= '0;
      s_q.cs_s <= 2'h3;
      s_q.cs_q <= 1'b1;
      s_q.cfg <= cfg_default();
      s_q.diag <= {8{DG_NORMAL}};
      s_q.so_oe_n <= 1'b1;
      s_q.fault_oe_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_channel_drain_output = s_q.on_q;
  assign o_slew_speed_select    = s_q.cfg.slew_speed_select;
  assign o_spi_so               = s_q.so;
  assign o_spi_so_oe_n          = s_q.so_oe_n;
  assign o_fault_o              = 1'b0;
  assign o_fault_oe_n           = s_q.fault_oe_n;
endmodule

// ===== tb/octal_switch_channel_control_assertions.sv
// port assertions for the octal switch channel control
`timescale 1ns/10ps
module octal_switch_channel_control_assertions (
  input wire logic                   i_sys_clk,
  input wire logic                   i_rst,
  input wire logic                   i_reset_n,
  input wire logic                   i_spi_cs_n,
  input wire oct_switch_pkg::sense_t i_sense,
  input wire logic [7:0]             o_channel_drain_output,
  input wire logic                   o_spi_so_oe_n,
  input wire logic                   o_fault_oe_n
);
  import oct_switch_pkg::*;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  property p_oe_on; $fell(i_spi_cs_n) && i_reset_n |-> ##[1:6] !o_spi_so_oe_n; endproperty
  a_oe_on: assert property (p_oe_on) else $error("so not driven");
  property p_oe_off; $rose(i_spi_cs_n) |-> ##[1:6] o_spi_so_oe_n; endproperty
  a_oe_off: assert property (p_oe_off) else $error("so not released");
  property p_so_hiz; i_spi_cs_n [*6] |-> o_spi_so_oe_n; endproperty
  a_so_hiz: assert property (p_so_hiz) else $error("so driven while idle");
  property p_so_drv; (!i_spi_cs_n && i_reset_n) [*6] |-> !o_spi_so_oe_n; endproperty
  a_so_drv: assert property (p_so_drv) else $error("so released in frame");
  property p_slp_off; !i_reset_n [*4] |-> o_channel_drain_output == 8'h00; endproperty
  a_slp_off: assert property (p_slp_off) else $error("output on in sleep");
  property p_slp_flt; !i_reset_n [*4] |-> o_fault_oe_n; endproperty
  a_slp_flt: assert property (p_slp_flt) else $error("fault kept in sleep");
  property p_ot_off; i_sense.overtemp[0] [*5] |-> !o_channel_drain_output[0]; endproperty
  a_ot_off: assert property (p_ot_off) else $error("channel on while hot");
  property p_flt_hold;
    (i_spi_cs_n && i_reset_n) [*8] ##0 !o_fault_oe_n |=> !o_fault_oe_n;
  endproperty
  a_flt_hold: assert property (p_flt_hold) else $error("fault dropped");
  c_flt: cover property ($fell(o_fault_oe_n));
  c_frame: cover property (!i_spi_cs_n ##1 i_spi_cs_n);
  c_ot: cover property ($fell(o_channel_drain_output[0]));
endmodule

// ===== tb/spi_host_model.sv
// host model that frames serial transfers to the switch
`timescale 1ns/10ps
module spi_host_model (
  output logic      o_cs_n,
  output logic      o_sclk,
  output logic      o_si,
  input  wire logic i_so
);
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_si   = 1'b0;
  end
  // n clocks of tx msb first, clock low at select edges
  task automatic xfer(input int n, input logic [15:0] tx, output logic [15:0] rx);
    rx = 16'h0000;
    o_cs_n = 1'b0;
    #201;
    for (int k = 0; k < n; k++) begin
      o_sclk = 1'b1;
      o_si   = tx[15-k];
      #62.5;
      rx     = {rx[14:0], i_so};
      o_sclk = 1'b0;
      #62.5;
    end
    o_si   = 1'b0;
    #100;
    o_cs_n = 1'b1;
    #300;
  endtask
endmodule

// ===== tb/octal_switch_channel_control_test.sv
// self-checking bench for the octal switch channel control
`timescale 1ns/10ps
module octal_switch_channel_control_test;
  import oct_switch_pkg::*;
  logic        i_sys_clk = 1'b0;
  logic        i_rst     = 1'b1;
  logic        i_reset_n = 1'b1;
  logic        pol       = 1'b1;
  logic [3:0]  pin       = 4'h0;
  sense_t      sense     = 32'h0000_0000;
  logic        cs_n, sclk, si, so, so_oe_n, flt_oe_n, flt_o;
  logic [7:0]  drain, slew;
  logic [15:0] rx;
  wire  [15:0] dr = {8'h00, drain};
  int          errors = 0;
  int          num_checks = 0;
  always #5 i_sys_clk = ~i_sys_clk;
  octal_switch_channel_control #(.FILT_CYCLES(5), .OVLD_CYCLES(10)) dut_u (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_reset_n(i_reset_n),
    .i_input_polarity_select(pol), .i_direct_parallel_input_a(pin[0]),
    .i_direct_parallel_input_b(pin[1]), .i_direct_parallel_input_c(pin[2]),
    .i_mappable_parallel_input(pin[3]), .i_spi_cs_n(cs_n), .i_spi_sclk(sclk),
    .i_spi_si(si), .i_sense(sense), .o_channel_drain_output(drain),
    .o_slew_speed_select(slew), .o_spi_so(so), .o_spi_so_oe_n(so_oe_n),
    .o_fault_o(flt_o), .o_fault_oe_n(flt_oe_n));
  spi_host_model host_u (.o_cs_n(cs_n), .o_sclk(sclk), .o_si(si), .i_so(so));
  task automatic chk(input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge i_sys_clk);
  endtask
  task automatic xf(input int n, input logic [15:0] tx);
    host_u.xfer(n, tx, rx);
    cyc(1);
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    xf(16, {CMD_WRITE, 3'h0, a, d});
  endtask
  task automatic t_sleep;
    wr(ADR_CTL, 8'hFF);
    chk(16'h00FF, dr);
    pin = 4'h1;
    i_reset_n = 1'b0;
    cyc(6);
    chk(16'h0000, dr);
    i_reset_n = 1'b1;
    cyc(6);
    chk(16'h0001, dr);
  endtask
  task automatic t_combine;
    wr(ADR_CTL, 8'h05);
    wr(ADR_BOL, 8'h03);
    pin = 4'h3;
    cyc(6);
    chk(16'h0005, dr);
    pin = 4'hF;
    pol = 1'b0;
    cyc(6);
    chk(16'h0004, dr);
    pin = 4'h0;
    cyc(6);
    chk(16'h000D, dr);
    pol = 1'b1;
  endtask
  task automatic t_map_read;
    wr(ADR_CTL, 8'h00);
    wr(ADR_MAP, 8'hF0);
    wr(ADR_SLE, 8'hA5);
    pin = 4'h8;
    cyc(6);
    chk(16'h00F0, dr);
    chk(16'h00A5, {8'h00, slew});
    xf(16, {CMD_READ, 3'h0, ADR_MAP, 8'h00});
    xf(16, {CMD_DIAG, 14'h0000});
    chk(READ_HDR | {5'h00, ADR_MAP, 8'hF0}, rx);
    xf(16, {CMD_RESET, 14'h0000});
    chk(16'hFFFF, rx);
    cyc(6);
    chk(16'h0008, dr);
    chk(16'h0000, {8'h00, slew});
    pin = 4'h0;
  endtask
  task automatic t_overtemp;
    wr(ADR_CTL, 8'h01);
    sense.overtemp = 8'h03;
    cyc(12);
    chk(16'h0000, dr);
    chk(16'h0000, {15'h0000, flt_oe_n});
    chk(16'h0000, {15'h0000, flt_o});
    sense.overtemp = 8'h00;
    cyc(6);
    chk(16'h0001, dr);
    xf(16, {CMD_DIAG, 14'h0000});
    chk(16'hFFFE, rx);
    cyc(6);
    chk(16'h0001, {15'h0000, flt_oe_n});
    wr(ADR_OVT, 8'h01);
    sense.overtemp = 8'h01;
    cyc(12);
    sense.overtemp = 8'h00;
    cyc(6);
    chk(16'h0000, dr);
    wr(ADR_CTL, 8'h00);
    wr(ADR_CTL, 8'h01);
    chk(16'h0001, dr);
  endtask
  task automatic t_overload;
    wr(ADR_OVL, 8'h02);
    wr(ADR_CTL, 8'h06);
    sense.current_limit = 8'h06;
    cyc(20);
    chk(16'h0004, dr);
    sense.current_limit = 8'h00;
    cyc(6);
    chk(16'h0004, dr);
    xf(16, {CMD_DIAG, 14'h0000});
    chk(16'hFFEB, rx);
    wr(ADR_CTL, 8'h04);
    wr(ADR_CTL, 8'h06);
    chk(16'h0006, dr);
  endtask
  task automatic t_frame;
    sense.current_limit = 8'h04;
    cyc(12);
    xf(7, {CMD_WRITE, 3'h0, ADR_CTL, 8'h00});
    xf(0, 16'h0000);
    chk(16'h0006, dr);
    chk(16'h0000, {15'h0000, flt_oe_n});
    chk(16'h0001, {15'h0000, so_oe_n});
    sense.current_limit = 8'h00;
    xf(16, {CMD_DIAG, 14'h0000});
    chk(16'hFFEF, rx);
    xf(16, {CMD_READ, 3'h0, ADR_STA, 8'h00});
    xf(16, {CMD_DIAG, 14'h0000});
    chk(READ_HDR | {5'h00, ADR_STA, 8'h06}, rx);
    sense.open_load = 8'h80;
    sense.short_gnd = 8'h40;
    cyc(6);
    chk(16'h0000, {15'h0000, flt_oe_n});
    sense = 32'h0000_0000;
    xf(16, {CMD_DIAG, 14'h0000});
    chk(16'h4FFF, rx);
  endtask
  task automatic results;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    cyc(4);
    i_rst = 1'b0;
    cyc(3);
    chk(16'h0300, {6'h00, so_oe_n, flt_oe_n, drain});
    t_sleep;
    t_combine;
    t_map_read;
    t_overtemp;
    t_overload;
    t_frame;
    results;
  end
  initial begin
    #500us;
    errors++;
    results;
  end
endmodule
bind octal_switch_channel_control octal_switch_channel_control_assertions chk_u (
  .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_reset_n(i_reset_n), .i_spi_cs_n(i_spi_cs_n),
  .i_sense(i_sense), .o_channel_drain_output(o_channel_drain_output),
  .o_spi_so_oe_n(o_spi_so_oe_n), .o_fault_oe_n(o_fault_oe_n));
